/* verilog/rbml_reset_boot_latch.v */
`timescale 1ns/1ps
`default_nettype none
`include "rbml_defines.vh"

module rbml_reset_boot_latch
(
   input  wire                    clk_i,
   input  wire                    ce_i,
   input  wire                    reset_n_i,
   input  wire                    low_voltage_i,
   input  wire                    soft_reset_i,
   input  wire                    watchdog_timeout_i,
   input  wire                    boot_done_i,
   input  wire                    boot_select_a_i,
   input  wire                    boot_select_b_i,
   input  wire                    boot_select_c_i,
   input  wire [`RBML_PORT_W-1:0] port_h_out_i,
   input  wire [`RBML_PORT_W-1:0] port_h_oe_i,
   output reg  [`RBML_MODE_W-1:0] boot_mode_o,
   output reg                     boot_mode_valid_o,
   output reg                     bootstrap_o,
   output reg                     core_reset_o,
   output reg                     reset_out_pin_o,
   output reg  [`RBML_PORT_W-1:0] port_h_in_o,
   output reg  [`RBML_PORT_W-1:0] port_h_pin_o,
   output reg  [`RBML_PORT_W-1:0] port_h_pin_oe_o
);

   // ----------------------------------------
   // States
   // ----------------------------------------
   localparam [`RBML_ST_W-1:0] ST_RESET = `RBML_ST_RESET;
   localparam [`RBML_ST_W-1:0] ST_LATCH = `RBML_ST_LATCH;
   localparam [`RBML_ST_W-1:0] ST_BOOT  = `RBML_ST_BOOT;
   localparam [`RBML_ST_W-1:0] ST_RUN   = `RBML_ST_RUN;

   reg  [`RBML_ST_W-1:0]   state;
   reg  [`RBML_ST_W-1:0]   next_state;
   reg  [`RBML_MODE_W-1:0] next_boot_mode;
   reg                     next_boot_mode_valid;
   reg                     next_bootstrap;
   reg                     next_core_reset;
   reg                     next_reset_out_pin;
   reg  [`RBML_PORT_W-1:0] next_port_h_in;
   wire                    released;
   wire                    internal_src;
   wire                    enter_reset;
   wire                    gpio_mode;
   wire                    next_gpio_mode;
   wire [`RBML_PORT_W-1:0] pins;
   wire [`RBML_PORT_W-1:0] next_port_h_pin;
   wire [`RBML_PORT_W-1:0] next_port_h_pin_oe;

   // ----------------------------------------
   // Reset sources and strap pins
   // ----------------------------------------
   // R5: internal reset sources
   assign internal_src = low_voltage_i | soft_reset_i | watchdog_timeout_i;
   // R2: mode word is c, b, a
   assign pins         = {boot_select_c_i, boot_select_b_i, boot_select_a_i};

   // ----------------------------------------
   // Release synchroniser
   // ----------------------------------------
   rbml_sync rbml_sync_inst
   (
      .clk_i      (clk_i),
      .ce_i       (ce_i),
      .reset_n_i  (reset_n_i),
      .released_o (released)
   );

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always @*
   begin
      next_state = state;
      case (state)
         ST_RESET:
         begin
            // R7: wait for synchronised release
            if (released)
               next_state = ST_LATCH;
         end
         ST_LATCH:
         begin
            next_state = ST_BOOT;
         end
         ST_BOOT:
         begin
            if (boot_done_i)
               next_state = ST_RUN;
         end
         ST_RUN:
         begin
            next_state = ST_RUN;
         end
         default:
         begin
            next_state = ST_RESET;
         end
      endcase
      // Internal sources restart the sequence and re-sample the straps
      if (internal_src)
         next_state = ST_RESET;
   end

   assign enter_reset    = (next_state == ST_RESET);
   assign gpio_mode      = (state == ST_RUN);
   assign next_gpio_mode = (next_state == ST_RUN);

   // R1: reset holds state
   always @(posedge clk_i)
   begin
      if (!reset_n_i)
         state <= ST_RESET;
      else if (ce_i)
         state <= next_state;
   end

   // ----------------------------------------
   // Output next values
   // ----------------------------------------
   always @*
   begin
      // R5: any source drives output
      next_reset_out_pin = internal_src | enter_reset;
      next_core_reset    = internal_src | enter_reset;
      next_bootstrap     = (next_state == ST_BOOT);
      // R2: latch straps at release
      next_boot_mode     = boot_mode_o;
      if (state == ST_LATCH)
         next_boot_mode = pins;
      // Reset entry beats a capture in the same cycle, so no stale valid
      next_boot_mode_valid = boot_mode_valid_o;
      if (enter_reset)
         next_boot_mode_valid = 1'b0;
      else if (state == ST_LATCH)
         next_boot_mode_valid = 1'b1;
      // R4: straps hidden until bootstrap ends
      next_port_h_in = gpio_mode ? pins : `RBML_PORT_RST;
   end

   // ----------------------------------------
   // Output registers
   // ----------------------------------------
   // R1: reset clears mode
   always @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         boot_mode_o       <= `RBML_MODE_RST;
         boot_mode_valid_o <= 1'b0;
      end
      else if (ce_i)
      begin
         boot_mode_o       <= next_boot_mode;
         boot_mode_valid_o <= next_boot_mode_valid;
      end
   end

   // R1: reset holds core
   always @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         bootstrap_o  <= 1'b0;
         core_reset_o <= 1'b1;
      end
      else if (ce_i)
      begin
         bootstrap_o  <= next_bootstrap;
         core_reset_o <= next_core_reset;
      end
   end

   // R5: reset output pin
   always @(posedge clk_i)
   begin
      if (!reset_n_i)
         reset_out_pin_o <= 1'b1;
      else if (ce_i)
         reset_out_pin_o <= next_reset_out_pin;
   end

   // R4: port input sample
   always @(posedge clk_i)
   begin
      if (!reset_n_i)
         port_h_in_o <= `RBML_PORT_RST;
      else if (ce_i)
         port_h_in_o <= next_port_h_in;
   end

   // R3: pin drive registers
   always @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         port_h_pin_o    <= `RBML_PORT_RST;
         port_h_pin_oe_o <= `RBML_PORT_RST;
      end
      else if (ce_i)
      begin
         port_h_pin_o    <= next_port_h_pin;
         port_h_pin_oe_o <= next_port_h_pin_oe;
      end
   end

   // ----------------------------------------
   // Port H pin handover
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < `RBML_PORT_W; g = g + 1)
      begin : g_port
         // R3: bit0 after bootstrap
         // R4: bits 1, 2 after bootstrap
         // Driven from the next state so the pin is free on the RUN edge
         assign next_port_h_pin[g]    = next_gpio_mode & port_h_out_i[g];
         assign next_port_h_pin_oe[g] = next_gpio_mode & port_h_oe_i[g];
      end
   endgenerate

endmodule
`default_nettype wire

/* verilog/rbml_defines.vh */
// Functional notes
// R1: Hold all state while reset input low
// R2: Latch three mode pins at reset release
// R3: First mode pin becomes port H bit0
// R4: Pins two, three become GPIO after bootstrap
// R5: Reset output on any reset source
// R6: Host asserts reset with TRST together
// R7: Synchronise reset release before mode latch
`ifndef RBML_DEFINES_VH
`define RBML_DEFINES_VH

// ----------------------------------------
// Widths and reset values
// ----------------------------------------
`define RBML_MODE_W        3
`define RBML_MODE_RST      3'h0
`define RBML_PORT_W        3
`define RBML_PORT_RST      3'h0
`define RBML_SYNC_W        2
`define RBML_SYNC_RST      2'h0
`define RBML_SYNC_SET      2'h3
`define RBML_SYNC_OUT      1

// ----------------------------------------
// One-hot sequencer states
// ----------------------------------------
`define RBML_ST_W          4
`define RBML_ST_RESET      4'h1
`define RBML_ST_LATCH      4'h2
`define RBML_ST_BOOT       4'h4
`define RBML_ST_RUN        4'h8

`endif

/* verilog/rbml_sync.v */
`timescale 1ns/1ps
`default_nettype none
`include "rbml_defines.vh"

// ----------------------------------------
// Reset release synchroniser
// ----------------------------------------
module rbml_sync
(
   input  wire clk_i,
   input  wire ce_i,
   input  wire reset_n_i,
   output wire released_o
);

   reg [`RBML_SYNC_W-1:0] stage;

   // R7: two flop release
   always @(posedge clk_i)
   begin
      if (!reset_n_i)
         stage <= `RBML_SYNC_RST;
      else if (ce_i)
         stage <= {stage[0], 1'b1};
   end

   // Only the second stage is read
   assign released_o = stage[`RBML_SYNC_OUT];

endmodule
`default_nettype wire

/* dv/rbml_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module rbml_props
(
   input wire       clk_i, ce_i, reset_n_i, low_voltage_i, soft_reset_i, watchdog_timeout_i,
   input wire       boot_select_a_i, boot_select_b_i, boot_select_c_i, boot_mode_valid_o,
   input wire       bootstrap_o, core_reset_o, reset_out_pin_o,
   input wire [2:0] port_h_oe_i, port_h_pin_oe_o, boot_mode_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   AST_HOLD: assert property (disable iff (1'b0) !reset_n_i |=> core_reset_o
      && reset_out_pin_o && !boot_mode_valid_o) else $error("reset not held");
   AST_CAPTURE: assert property ($rose(boot_mode_valid_o) |-> boot_mode_o ==
      $past({boot_select_c_i, boot_select_b_i, boot_select_a_i})) else $error("bad mode");
   AST_BOOT_HOLD: assert property (bootstrap_o |-> port_h_pin_oe_o == 3'h0)
      else $error("drive in boot");
   AST_RUN: assert property ($past(ce_i) && boot_mode_valid_o && !bootstrap_o
      && !core_reset_o |-> port_h_pin_oe_o == $past(port_h_oe_i))
      else $error("no drive in run");
   AST_SRC: assert property (ce_i && (low_voltage_i || soft_reset_i || watchdog_timeout_i)
      |=> reset_out_pin_o && !boot_mode_valid_o) else $error("source missed");
   AST_SYNC: assert property ($rose(reset_n_i) |-> !boot_mode_valid_o ##1 !boot_mode_valid_o)
      else $error("latched early");
endmodule
bind rbml_reset_boot_latch rbml_props rbml_props_inst
(
   .clk_i              (clk_i),
   .ce_i               (ce_i),
   .reset_n_i          (reset_n_i),
   .low_voltage_i      (low_voltage_i),
   .soft_reset_i       (soft_reset_i),
   .watchdog_timeout_i (watchdog_timeout_i),
   .boot_select_a_i    (boot_select_a_i),
   .boot_select_b_i    (boot_select_b_i),
   .boot_select_c_i    (boot_select_c_i),
   .boot_mode_valid_o  (boot_mode_valid_o),
   .bootstrap_o        (bootstrap_o),
   .core_reset_o       (core_reset_o),
   .reset_out_pin_o    (reset_out_pin_o),
   .port_h_oe_i        (port_h_oe_i),
   .port_h_pin_oe_o    (port_h_pin_oe_o),
   .boot_mode_o        (boot_mode_o)
);
`default_nettype wire

/* dv/rbml_board.sv */
`timescale 1ns/1ps
`default_nettype none
module rbml_board
(
   input  wire       clk_i,
   output reg        reset_n_o,
   output reg  [2:0] strap_o
);
   task hold_reset(input [2:0] md);
   begin
      reset_n_o = 1'b0;
      strap_o = md;
      repeat (3) @(negedge clk_i);
      reset_n_o = 1'b1;
   end
   endtask
   // Straps may move in run, they only count at the next latch
   task set_strap(input [2:0] md);
   begin
      strap_o = md;
   end
   endtask
endmodule
`default_nettype wire

/* dv/test_reset_boot_mode_latch.sv */
`timescale 1ns/1ps
`default_nettype none
module test_reset_boot_mode_latch;
   reg        clk_i, ce_i, boot_done_i, low_voltage_i, soft_reset_i, watchdog_timeout_i;
   reg  [2:0] port_h_out_i, port_h_oe_i;
   wire       reset_n_i, boot_select_a_i, boot_select_b_i, boot_select_c_i;
   wire       boot_mode_valid_o, bootstrap_o, core_reset_o, reset_out_pin_o;
   wire [2:0] boot_mode_o, port_h_in_o, port_h_pin_o, port_h_pin_oe_o;
   integer    bad_count = 0, total_checks = 0, cyc = 0, m, i;
   rbml_board rbml_board_inst (.clk_i(clk_i), .reset_n_o(reset_n_i),
      .strap_o({boot_select_c_i, boot_select_b_i, boot_select_a_i}));
   rbml_reset_boot_latch rbml_reset_boot_latch_inst
   (
      .clk_i              (clk_i),
      .ce_i               (ce_i),
      .reset_n_i          (reset_n_i),
      .low_voltage_i      (low_voltage_i),
      .soft_reset_i       (soft_reset_i),
      .watchdog_timeout_i (watchdog_timeout_i),
      .boot_done_i        (boot_done_i),
      .boot_select_a_i    (boot_select_a_i),
      .boot_select_b_i    (boot_select_b_i),
      .boot_select_c_i    (boot_select_c_i),
      .port_h_out_i       (port_h_out_i),
      .port_h_oe_i        (port_h_oe_i),
      .boot_mode_o        (boot_mode_o),
      .boot_mode_valid_o  (boot_mode_valid_o),
      .bootstrap_o        (bootstrap_o),
      .core_reset_o       (core_reset_o),
      .reset_out_pin_o    (reset_out_pin_o),
      .port_h_in_o        (port_h_in_o),
      .port_h_pin_o       (port_h_pin_o),
      .port_h_pin_oe_o    (port_h_pin_oe_o)
   );
   task check(input [23:0] n, input [2:0] s, input [2:0] e);
   begin
      total_checks = total_checks + 1;
      if (s !== e)
      begin
         bad_count = bad_count + 1;
         $display("mismatch %0s exp %h seen %h", n, e, s);
      end
   end
   endtask
   task wrap_up;
   begin
      $display("checks %0d bad %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   end
   endtask
   task boot(input [2:0] md, input frz);
   begin
      for (i = 0; i < 9 && bootstrap_o !== 1'b1; i = i + 1)
         @(negedge clk_i);
      check("bst", {2'h0, bootstrap_o}, 3'h1);
      check("md", boot_mode_o, md);
      check("vld", {2'h0, boot_mode_valid_o}, 3'h1);
      check("boe", port_h_pin_oe_o, 3'h0);
      check("bpn", port_h_pin_o, 3'h0);
      check("bin", port_h_in_o, 3'h0);
      boot_done_i = 1'b1;
      if (frz)
      begin
         ce_i = 1'b0;
         repeat (2) @(negedge clk_i);
         check("frz", {2'h0, bootstrap_o}, 3'h1);
         ce_i = 1'b1;
      end
      @(negedge clk_i) boot_done_i = 1'b0;
      check("roe", port_h_pin_oe_o, port_h_oe_i);
      check("rpn", port_h_pin_o, port_h_out_i);
      @(negedge clk_i);
      check("rin", port_h_in_o, md);
   end
   endtask
   // Any source must also clear boot_mode_valid_o; boot_mode_o keeps its old value until the next latch
   task sources;
   begin
      for (m = 0; m < 3; m = m + 1)
      begin
         rbml_board_inst.set_strap(m[2:0]);
         {watchdog_timeout_i, soft_reset_i, low_voltage_i} = 3'h1 << m;
         @(negedge clk_i) {watchdog_timeout_i, soft_reset_i, low_voltage_i} = 3'h0;
         check("src", {core_reset_o, reset_out_pin_o, boot_mode_valid_o}, 3'h6);
         boot(m[2:0], m == 1);
      end
   end
   endtask
   initial
   begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   always @(posedge clk_i)
   begin
      cyc = cyc + 1;
      if (cyc == 1000)
      begin
         bad_count = bad_count + 1;
         wrap_up;
      end
   end
   initial
   begin
      {ce_i, boot_done_i, low_voltage_i, soft_reset_i, watchdog_timeout_i} = 5'h10;
      port_h_out_i = 3'h3;
      port_h_oe_i = 3'h5;
      for (m = 0; m < 8; m = m + 1)
      begin
         rbml_board_inst.hold_reset(m[2:0]);
         check("rst", {core_reset_o, reset_out_pin_o, boot_mode_valid_o}, 3'h6);
         boot(m[2:0], 1'b0);
      end
      sources;
      wrap_up;
   end
endmodule
`default_nettype wire
